// ### hw/svi_consts.vh
// Constants of the six-source vectored interrupt unit: offsets, bit positions, vectors.
// Assumes a 32-bit AXI4-Lite register bus; offsets are word indices (byte address over four).
//
// Behaviour
// RL1: Six sources: two pins, two timers, tick, rtc
// RL2: Acceptance clears master enable; others only latch
// RL3: Software re-enable inside handler allows nesting
// RL4: No acknowledge while return stack full
// RL5: Any source request wakes the halted device
// RL6: Only program counter pushed, then vector branch
// RL7: Pin edges set flags at primary bits 4,5
// RL8: Pins vector 04H/08H, clear flag and master
// RL9: Timer A flag bit 6, vector 0CH
// RL10: Timer B flag secondary bit 4, vector 10H
// RL11: Tick flag secondary bit 5, vector 14H
// RL12: Primary bits 0-3: master, ext0, ext1, timer A
// RL13: Software writes zero to primary bit 7
// RL14: Primary index 0BH, secondary index 1EH
// RL15: Rtc flag secondary bit 6, vector 18H
// RL16: Fixed priority ext0 first, rtc last
// RL17: Secondary enables bits 0-2; bits 3,7 zero
// RL18: Flags stay set until serviced or cleared
`ifndef SVI_CONSTS_VH
`define SVI_CONSTS_VH

`define SVI_IDX_PRIMARY      8'h0B
`define SVI_IDX_SECONDARY    8'h1E
`define SVI_IDX_STATUS       8'h20
`define SVI_ADDR_W           8

`define SVI_P_MASTER         0
`define SVI_P_EXT0_EN        1
`define SVI_P_EXT1_EN        2
`define SVI_P_TIMA_EN        3
`define SVI_P_EXT0_FLAG      4
`define SVI_P_EXT1_FLAG      5
`define SVI_P_TIMA_FLAG      6
`define SVI_P_TEST           7

`define SVI_S_TIMB_EN        0
`define SVI_S_TICK_EN        1
`define SVI_S_RTC_EN         2
`define SVI_S_TIMB_FLAG      4
`define SVI_S_TICK_FLAG      5
`define SVI_S_RTC_FLAG       6

`define SVI_VEC_EXT0         8'h04
`define SVI_VEC_EXT1         8'h08
`define SVI_VEC_TIMA         8'h0C
`define SVI_VEC_TIMB         8'h10
`define SVI_VEC_TICK         8'h14
`define SVI_VEC_RTC          8'h18

`define SVI_RESET_PRIMARY    8'h00
`define SVI_RESET_SECONDARY  8'h00
`define SVI_STACK_DEPTH      16
`define SVI_RESP_OKAY        2'b00
`define SVI_RESP_DECERR      2'b11

`endif

// ### hw/svi_edge_detect.v
// Edge detector for the two external request pins.
// Assumes pins are already synchronous to clk; polarity is a fixed option.
`timescale 1ns/1ps
module svi_edge_detect #(
    parameter FALLING = 1
) (
    input  wire clk,
    input  wire reset,
    input  wire clk_en,
    input  wire pin,
    output wire edge_seen
);
    reg pin_last;

    // Starts at the idle level of the chosen edge so reset makes no false edge
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_last <= (FALLING != 0) ? 1'b1 : 1'b0;
        end else if (clk_en) begin
            pin_last <= pin;
        end
    end

    assign edge_seen = (FALLING != 0) ? (pin_last & ~pin) : (~pin_last & pin);  // [RL7]
endmodule // svi_edge_detect

// ### hw/svi_unit.v
// Six-source vectored interrupt unit with AXI4-Lite access to both control registers.
// Assumes the core sequencer samples ack_valid/vector at its sampling edge and
// reports stack depth and returns; event sources give one-cycle pulses.
`include "svi_consts.vh"
`timescale 1ns/1ps
module svi_unit #(
    parameter EXT0_FALLING = 1,
    parameter EXT1_FALLING = 1,
    parameter STACK_DEPTH  = `SVI_STACK_DEPTH
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        clk_en,
    input  wire        ext_irq_pin_a,
    input  wire        ext_irq_pin_b,
    input  wire        timer_a_overflow,
    input  wire        timer_b_overflow,
    input  wire        tick_event,
    input  wire        rtc_event,
    input  wire        sample_strobe,
    input  wire        stack_full,
    input  wire        return_and_reenable,
    output reg         ack_valid,
    output reg  [7:0]  ack_vector,
    output reg         push_pc,
    output reg         wake,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    // Request flags and enables, priority order ext0, ext1, timer A, timer B, tick, rtc
    reg        master_irq_enable;
    reg        ext0_irq_enable;
    reg        ext1_irq_enable;
    reg        timer_a_irq_enable;
    reg        timer_b_irq_enable;
    reg        tick_irq_enable;
    reg        rtc_irq_enable;
    reg        test_bit;
    reg  [5:0] flags;
    reg  [31:0] aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    reg         stack_full_seen;

    wire       ext0_edge;
    wire       ext1_edge;
    wire [5:0] raw_events;
    wire [5:0] enables;
    wire [5:0] eligible;
    reg  [5:0] grant;
    reg  [7:0] next_vector;

    svi_edge_detect #(.FALLING(EXT0_FALLING)) u_edge_a (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin       (ext_irq_pin_a),
        .edge_seen (ext0_edge)
    );

    svi_edge_detect #(.FALLING(EXT1_FALLING)) u_edge_b (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin       (ext_irq_pin_b),
        .edge_seen (ext1_edge)
    );

    assign raw_events = {rtc_event, tick_event, timer_b_overflow, timer_a_overflow,
                         ext1_edge, ext0_edge};  // [RL1]
    assign enables    = {rtc_irq_enable, tick_irq_enable, timer_b_irq_enable,
                         timer_a_irq_enable, ext1_irq_enable, ext0_irq_enable};
    // Stack fullness gates acknowledgment only; flags keep pending  [RL4]
    assign eligible   = (master_irq_enable && !stack_full) ? (flags & enables) : 6'h00;

    // Lowest index wins  [RL16]
    always @* begin
        grant       = 6'h00;
        next_vector = 8'h00;
        if (eligible[0]) begin
            grant = 6'h01;
            next_vector = `SVI_VEC_EXT0;  // [RL8]
        end else if (eligible[1]) begin
            grant = 6'h02;
            next_vector = `SVI_VEC_EXT1;  // [RL8]
        end else if (eligible[2]) begin
            grant = 6'h04;
            next_vector = `SVI_VEC_TIMA;  // [RL9]
        end else if (eligible[3]) begin
            grant = 6'h08;
            next_vector = `SVI_VEC_TIMB;  // [RL10]
        end else if (eligible[4]) begin
            grant = 6'h10;
            next_vector = `SVI_VEC_TICK;  // [RL11]
        end else if (eligible[5]) begin
            grant = 6'h20;
            next_vector = `SVI_VEC_RTC;   // [RL15]
        end
    end

    wire take_irq = sample_strobe && (grant != 6'h00);

    // Bus write decode
    wire       do_write  = aw_held && w_held && !s_axi_bvalid;
    wire [7:0] w_index   = aw_addr[`SVI_ADDR_W+1:2];
    wire       w_aligned = (aw_addr[1:0] == 2'b00) && (aw_addr[31:`SVI_ADDR_W+2] == 22'h0);

    // Write target decode; only byte lane 0 carries register data
    reg        wr_pri;
    reg        wr_sec;
    reg        wr_stat;
    reg        w_hit;
    always @* begin
        wr_pri  = 1'b0;
        wr_sec  = 1'b0;
        wr_stat = 1'b0;
        w_hit   = 1'b0;
        if (!w_aligned) begin
            // Misaligned or out of range: answered with an error, nothing written
            w_hit = 1'b0;
        end else if (w_index == `SVI_IDX_PRIMARY) begin
            w_hit  = 1'b1;
            wr_pri = do_write && w_strb[0];
        end else if (w_index == `SVI_IDX_SECONDARY) begin
            w_hit  = 1'b1;
            wr_sec = do_write && w_strb[0];
        end else if (w_index == `SVI_IDX_STATUS) begin
            w_hit   = 1'b1;
            wr_stat = do_write && w_strb[0];
        end
    end

    // Software writes apply first, then hardware sets win over a cleared flag
    reg [5:0] next_flags;
    always @* begin
        next_flags = flags;
        if (wr_pri) begin
            next_flags[2:0] = w_data[6:4];
        end
        if (wr_sec) begin
            next_flags[5:3] = w_data[6:4];
        end
        if (take_irq) begin
            next_flags = next_flags & ~grant;  // [RL8] [RL9] [RL10] [RL11] [RL15]
        end
        next_flags = next_flags | raw_events;  // [RL7] [RL18]
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            flags              <= 6'h00;
            master_irq_enable  <= 1'b0;
            ext0_irq_enable    <= 1'b0;
            ext1_irq_enable    <= 1'b0;
            timer_a_irq_enable <= 1'b0;
            timer_b_irq_enable <= 1'b0;
            tick_irq_enable    <= 1'b0;
            rtc_irq_enable     <= 1'b0;
            test_bit           <= 1'b0;
            ack_valid          <= 1'b0;
            ack_vector         <= 8'h00;
            push_pc            <= 1'b0;
            wake               <= 1'b0;
        end else if (clk_en) begin
            flags <= next_flags;
            if (wr_pri) begin  // [RL12] [RL14]
                master_irq_enable  <= w_data[`SVI_P_MASTER];  // [RL3]
                ext0_irq_enable    <= w_data[`SVI_P_EXT0_EN];
                ext1_irq_enable    <= w_data[`SVI_P_EXT1_EN];
                timer_a_irq_enable <= w_data[`SVI_P_TIMA_EN];
                // Kept only for readback; nothing here acts on test mode
                test_bit           <= w_data[`SVI_P_TEST];  // [RL13]
            end
            if (wr_sec) begin  // [RL17] [RL14]
                timer_b_irq_enable <= w_data[`SVI_S_TIMB_EN];
                tick_irq_enable    <= w_data[`SVI_S_TICK_EN];
                rtc_irq_enable     <= w_data[`SVI_S_RTC_EN];
            end
            // Return with reenable sets master; acceptance clears it last  [RL2]
            if (return_and_reenable) begin
                master_irq_enable <= 1'b1;
            end
            if (take_irq) begin
                master_irq_enable <= 1'b0;  // [RL2]
            end
            ack_valid  <= take_irq;
            push_pc    <= take_irq;  // [RL6]
            ack_vector <= take_irq ? next_vector : 8'h00;
            // Enables are ignored here so a masked source still ends the halt
            wake       <= (flags != 6'h00) || (raw_events != 6'h00);  // [RL5]
        end
    end

    // Stack-full events seen, readable as a diagnostic
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stack_full_seen <= 1'b0;
        end else if (clk_en) begin
            if (sample_strobe && stack_full && master_irq_enable &&
                ((flags & enables) != 6'h00)) begin
                stack_full_seen <= 1'b1;
            end else if (wr_stat && w_data[0]) begin
                stack_full_seen <= 1'b0;
            end
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    // A second address or data word is refused while one is held unused
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_addr       <= 32'h0000_0000;
            aw_held       <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SVI_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_hit ? `SVI_RESP_OKAY : `SVI_RESP_DECERR;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    wire [7:0] r_index   = s_axi_araddr[`SVI_ADDR_W+1:2];
    wire       r_aligned = (s_axi_araddr[1:0] == 2'b00) &&
                           (s_axi_araddr[31:`SVI_ADDR_W+2] == 22'h0);
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `SVI_RESP_OKAY;
        if (r_aligned && (r_index == `SVI_IDX_PRIMARY)) begin
            next_rdata[7:0] = {test_bit, flags[2:0], timer_a_irq_enable, ext1_irq_enable,
                               ext0_irq_enable, master_irq_enable};
        end else if (r_aligned && (r_index == `SVI_IDX_SECONDARY)) begin
            next_rdata[7:0] = {1'b0, flags[5:3], 1'b0, rtc_irq_enable, tick_irq_enable,
                               timer_b_irq_enable};  // [RL17]
        end else if (r_aligned && (r_index == `SVI_IDX_STATUS)) begin
            next_rdata[1:0] = {stack_full, stack_full_seen};
        end else begin
            next_rresp = `SVI_RESP_DECERR;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SVI_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= next_rresp;
                s_axi_rvalid  <= 1'b1;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // svi_unit

// ### tb/svi_unit_properties.sv
// Concurrent checks on the ports of the vectored interrupt unit.
// Assumes one clock domain, asynchronous active-high reset, clk_en held high.
`timescale 1ns/1ps
module svi_checker (
    input logic        clk,
    input logic        reset,
    input logic        timer_a_overflow,
    input logic        tick_event,
    input logic        rtc_event,
    input logic        sample_strobe,
    input logic        stack_full,
    input logic        ack_valid,
    input logic [7:0]  ack_vector,
    input logic        push_pc,
    input logic        wake,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Master enable drops on entry and the core model strobes every fourth edge, so two edges pass before the next entry
    property p_ack_gap;
        ack_valid |=> !ack_valid [*2];
    endproperty
    a_ack_gap: assert property (p_ack_gap) else $error("entry not followed by idle");
    property p_push_pc;
        push_pc == ack_valid;
    endproperty
    a_push_pc: assert property (p_push_pc) else $error("push differs from entry");
    property p_vec_idle;
        !ack_valid |-> ack_vector == 8'h00;
    endproperty
    a_vec_idle: assert property (p_vec_idle) else $error("vector outside entry");
    property p_vec_set;
        ack_valid |-> ack_vector inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    endproperty
    a_vec_set: assert property (p_vec_set) else $error("vector not a source");
    property p_need_room;
        ack_valid |-> $past(sample_strobe) && !$past(stack_full);
    endproperty
    a_need_room: assert property (p_need_room) else $error("entry without room");
    property p_wake;
        (tick_event || timer_a_overflow || rtc_event) |=> wake;
    endproperty
    a_wake: assert property (p_wake) else $error("event did not wake");
    property p_bhold;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response not retired");
    property p_rzero;
        s_axi_rvalid && s_axi_rresp == 2'b00 |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rzero: assert property (p_rzero) else $error("upper read bits set");
endmodule // svi_checker

bind svi_unit svi_checker u_chk (.clk(clk), .reset(reset), .timer_a_overflow(timer_a_overflow),
    .tick_event(tick_event), .rtc_event(rtc_event), .sample_strobe(sample_strobe),
    .stack_full(stack_full), .ack_valid(ack_valid), .ack_vector(ack_vector), .push_pc(push_pc),
    .wake(wake), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// ### tb/svi_core_model.sv
// Core sequencer model: sampling strobe, return stack depth, return with re-enable.
// Assumes push_pc is a one-cycle pulse per entry and ret_req a one-cycle pulse.
`timescale 1ns/1ps
module svi_core_model #(
    parameter int DEPTH = 2
) (
    input  logic clk,
    input  logic reset,
    input  logic push_pc,
    input  logic ret_req,
    output logic sample_strobe,
    output logic stack_full,
    output logic return_and_reenable
);
    logic [1:0] phase;
    logic [4:0] depth;
    logic       pop;
    assign pop = ret_req && depth != 5'h00;
    assign stack_full = depth == 5'(DEPTH);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= 2'h0;
            depth <= 5'h00;
            sample_strobe <= 1'b0;
            return_and_reenable <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            sample_strobe <= phase == 2'h0;
            return_and_reenable <= pop;
            depth <= depth + {4'h0, push_pc} - {4'h0, pop};
        end
    end
endmodule // svi_core_model

// ### tb/six_source_vectored_interrupt_unit_tb.sv
// Self-checking bench for the vectored interrupt unit over AXI4-Lite.
// Assumes the core model answers strobes and stack depth; clk_en is held high.
`timescale 1ns/1ps
`include "svi_consts.vh"
module six_source_vectored_interrupt_unit_tb;
    localparam [31:0] PRI = {22'h0, `SVI_IDX_PRIMARY, 2'b00};
    localparam [31:0] SEC = {22'h0, `SVI_IDX_SECONDARY, 2'b00};
    reg         clk, reset, ret_req, awvalid, wvalid, bready, arvalid, rready, hit;
    reg  [5:0]  ev;
    reg  [7:0]  vec, rv;
    reg  [1:0]  resp;
    reg  [31:0] awaddr, wdata, araddr, rd_data, seed;
    wire        awready, wready, bvalid, arready, rvalid, ack_valid, push_pc, wake, strb;
    wire        full, rre;
    wire [1:0]  bresp, rresp;
    wire [7:0]  ack_vector;
    wire [31:0] rdata;
    integer     n_fail, samples_checked, k, j;

    svi_unit dut (.clk(clk), .reset(reset), .clk_en(1'b1), .ext_irq_pin_a(~ev[0]),
        .ext_irq_pin_b(~ev[1]), .timer_a_overflow(ev[2]), .timer_b_overflow(ev[3]),
        .tick_event(ev[4]), .rtc_event(ev[5]), .sample_strobe(strb), .stack_full(full),
        .return_and_reenable(rre), .ack_valid(ack_valid), .ack_vector(ack_vector),
        .push_pc(push_pc), .wake(wake), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    svi_core_model #(.DEPTH(2)) core (.clk(clk), .reset(reset), .push_pc(push_pc),
        .ret_req(ret_req), .sample_strobe(strb), .stack_full(full), .return_and_reenable(rre));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    function automatic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Flags still pending after services 0 to k, priority order from ext0
    function automatic [31:0] exp_reg(input integer kk, input bit hi);
        reg [5:0] p;
        p = 6'h3F << (kk + 1);
        return hi ? {25'h0, p[5:3], 4'h7} : {25'h0, p[2:0], 4'hE};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task tmo;
        chk(0, 1);
        conclude;
    endtask
    // Response ready stands from the start until the answer is sampled
    task wr(input [31:0] a, input [7:0] d);
        integer i;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid && bready) break;
        end
        if (i == 50) tmo;
        bready <= 0;
    endtask
    task rd(input [31:0] a);
        integer i;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                rd_data = rdata; resp = rresp;
                break;
            end
        end
        if (i == 50) tmo;
        rready <= 0;
    endtask
    task fire(input integer s);
        @(posedge clk) ev <= 6'h01 << s;
        @(posedge clk) ev <= 6'h00;
    endtask
    task wait_ack(input integer n);
        integer i;
        hit = 0;
        for (i = 0; i < n && !hit; i++) begin
            @(posedge clk);
            if (ack_valid === 1'b1) begin
                hit = 1; vec = ack_vector;
            end
        end
    endtask
    task ret;
        @(posedge clk) ret_req <= 1;
        @(posedge clk) ret_req <= 0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        tmo;
    end
    initial begin
        reset = 1; ev = 0; ret_req = 0; awaddr = 0; wdata = 0; araddr = 0; awvalid = 0;
        wvalid = 0; bready = 0; arvalid = 0; rready = 0; n_fail = 0; samples_checked = 0;
        seed = 15830;
        repeat (12) @(posedge clk);
        reset <= 0;
        rd(PRI); chk(rd_data, `SVI_RESET_PRIMARY);
        rd(SEC); chk(rd_data, `SVI_RESET_SECONDARY);
        rd(32'h4); chk(resp, `SVI_RESP_DECERR);
        wr(SEC, 8'hFF); rd(SEC); chk(rd_data, 32'h77);
        k = xs();
        rv = k[7:0];
        wr(SEC, rv); rd(SEC); chk(rd_data, {24'h0, rv & 8'h77});
        wr(SEC, 8'h00); rd(SEC); chk(rd_data, 32'h0);
        // Lowest priority first, random gaps: arrival order must not matter
        for (k = 5; k >= 0; k--) begin
            fire(k);
            repeat (xs() % 4) @(posedge clk);
        end
        chk(wake, 1);
        rd(PRI); chk(rd_data, 32'h70);
        rd(SEC); chk(rd_data, 32'h70);
        wr(SEC, 8'h77); wr(PRI, 8'h7F);
        for (k = 0; k < 6; k++) begin
            wait_ack(60); chk({hit, vec}, {1'b1, 6'(k + 1), 2'b00});
            rd(PRI); chk(rd_data, exp_reg(k, 0));
            rd(SEC); chk(rd_data, exp_reg(k, 1));
            ret;
        end
        // Core stack holds two entries; the third must wait for a return
        for (j = 0; j < 3; j++) begin
            wr(PRI, 8'h01); fire(4);
            wait_ack(60); chk(hit, j < 2);
        end
        rd(SEC); chk(rd_data, 32'h27);
        rd({22'h0, `SVI_IDX_STATUS, 2'b00}); chk(rd_data, 32'h3);
        ret; wait_ack(60); chk({hit, vec}, {1'b1, `SVI_VEC_TICK});
        conclude;
    end
endmodule // six_source_vectored_interrupt_unit_tb
